// ===== hdl/had_pkg.sv
// Purpose: shared constants for the host address decoder
// Assumes: 16-bit words, word-addressed space of 32K locations
// Notes: register slots below RAM_FIRST are flops, everything above is RAM
package had_pkg;
	localparam int WORD_W = 16;
	localparam int WADDR_W = 15;
	localparam int SPACE_WORDS = 32768;
	localparam int REG_SLOTS = 80;
	localparam logic [14:0] RAM_FIRST = 15'h004C;
	localparam logic [14:0] RAM_LAST = 15'h7FFF;
	localparam int REG_IMPL = 76;
	// relocatable structure base registers and their reset values
	localparam logic [6:0] LOG_ADDR_IDX = 7'h0A;
	localparam logic [15:0] LOG_ADDR_RST = 16'h0180;
	localparam logic [6:0] HW_IEN_IDX = 7'h0F;
	localparam logic [15:0] HW_IEN_RST = 16'h6018;
	localparam logic [6:0] HW_OEN_IDX = 7'h13;
	localparam logic [15:0] HW_OEN_RST = 16'h6018;
	localparam logic [6:0] RT1_DESC_IDX = 7'h19;
	localparam logic [15:0] RT1_DESC_RST = 16'h0400;
	localparam logic [6:0] RT2_DESC_IDX = 7'h22;
	localparam logic [15:0] RT2_DESC_RST = 16'h0600;
	// read-only protection masks, set bits are host writable
	localparam logic [15:0] MASK_RW = 16'hFFFF;
	localparam logic [15:0] MASK_RO = 16'h0000;
	localparam logic [15:0] MASK_LOG = 16'h07FF;
	localparam logic [15:0] LANE_LO = 16'h00FF;
	localparam logic [15:0] LANE_HI = 16'hFF00;
	localparam logic [1:0] BE_LO = 2'h1;
	localparam logic [1:0] BE_HI = 2'h2;
	localparam logic [1:0] BE_ALL = 2'h3;
endpackage : had_pkg

// ===== hdl/had_ram.sv
// Purpose: shared static RAM with byte enables and registered read
// Assumes: one access per clock, chosen by the arbiter in front of it
// Notes: read data holds until the next enabled access
`timescale 1ns/1ps
`default_nettype none
module had_ram #(
	parameter int AW = 15,
	parameter int DW = 16,
	parameter int DEPTH = 32768
) (
	input wire logic clk,
	input wire logic en,
	input wire logic we,
	input wire logic [1:0] be,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (en) begin
			if (we && be[0]) begin
				mem[addr][DW/2-1:0] <= wdata[DW/2-1:0];
			end
			if (we && be[1]) begin
				mem[addr][DW-1:DW/2] <= wdata[DW-1:DW/2];
			end
			rdata <= mem[addr];
		end
	end
endmodule : had_ram
`default_nettype wire

// ===== hdl/host_address_decoder.sv
// Purpose: decode host and internal accesses into registers and shared RAM
// Assumes: host and internal strobes are one-cycle pulses, synchronous to clk
// Notes: one shared access per cycle; answers come two edges after the grant
//
// Summary of operation
// - one space of 32K sixteen-bit words shared by registers and RAM.
// - registers overlay the lowest 76 word locations, 0x0000 to 0x004B.
// - word mode decodes the upper fifteen address inputs, lane input ignored.
// - byte mode uses all sixteen inputs, lowest picks the byte of the word.
// - register and RAM accesses share one procedure and timing.
// - host writes never change read-only registers or read-only fields.
// - word addresses 0x004C to 0x7FFF decode as static RAM.
// - host and internal logic may both read and write all RAM.
// - concurrent host and internal writes are arbitrated, none corrupted.
// - strap 1 selects the parallel host port, 0 selects the serial port.
// - registers and fixed structures sit at fixed addresses.
// - relocatable structures follow base registers with reset defaults.
// - register bits are active high, bit 15 most significant.
`timescale 1ns/1ps
`default_nettype none
module host_address_decoder #(
	parameter int NREG = had_pkg::REG_IMPL
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic busSelStrap,
	input wire logic byteMode,
	input wire logic [15:0] hostAddr,
	input wire logic hostRd,
	input wire logic hostWr,
	input wire logic [15:0] hostWdata,
	output logic [15:0] hostRdata,
	output logic hostAck,
	output logic hostBusy,
	output logic hostIfParallel,
	input wire logic [14:0] intAddr,
	input wire logic intRd,
	input wire logic intWr,
	input wire logic [15:0] intWdata,
	output logic [15:0] intRdata,
	output logic intAck,
	output logic intBusy,
	output logic [15:0] logBase,
	output logic [15:0] rt1DescBase,
	output logic [15:0] rt2DescBase
);
	typedef struct packed {
		logic [NREG-1:0][15:0] regs;
		logic strapDone;
		logic busPar;
		logic hPend;
		logic hBusy;
		logic hWe;
		logic hByte;
		logic hLane;
		logic [14:0] hAddr;
		logic [15:0] hData;
		logic iPend;
		logic iBusy;
		logic iWe;
		logic [14:0] iAddr;
		logic [15:0] iData;
		logic lastHost;
		logic s1Host;
		logic s1Int;
		logic s1Reg;
		logic s1Byte;
		logic s1Lane;
		logic [15:0] s1RegVal;
		logic hAck;
		logic iAck;
		logic [15:0] hRdata;
		logic [15:0] iRdata;
	} had_state_type;

	had_state_type st_r;
	had_state_type st_nxt;
	logic grantHost;
	logic grantInt;
	logic [14:0] gAddr;
	logic isReg;
	logic ramEn;
	logic ramWe;
	logic [1:0] ramBe;
	logic [15:0] ramWdata;
	logic [15:0] ramRdata;
	logic [15:0] rdWord;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// host-writable bits of each register; clear bits are read-only
	function automatic logic [15:0] hostWrMask(input logic [6:0] idx);
		if (idx == 7'h01 || idx == 7'h02 || idx == 7'h03 || idx == 7'h04 || idx == 7'h05) begin
			return had_pkg::MASK_RO;
		end else if (idx >= 7'h06 && idx <= 7'h09) begin
			return had_pkg::MASK_RO;
		end else if (idx == had_pkg::LOG_ADDR_IDX) begin
			return had_pkg::MASK_LOG;
		end else begin
			return had_pkg::MASK_RW;
		end
	endfunction : hostWrMask

	// lane mask for a write, whole word unless byte mode
	function automatic logic [15:0] laneMask(input logic byteSel, input logic lane);
		if (!byteSel) begin
			return had_pkg::MASK_RW;
		end else if (lane) begin
			return had_pkg::LANE_HI;
		end else begin
			return had_pkg::LANE_LO;
		end
	endfunction : laneMask

	function automatic logic [NREG-1:0][15:0] regReset();
		logic [NREG-1:0][15:0] r;
		r = '0;
		r[had_pkg::LOG_ADDR_IDX] = had_pkg::LOG_ADDR_RST;
		r[had_pkg::HW_IEN_IDX] = had_pkg::HW_IEN_RST;
		r[had_pkg::HW_OEN_IDX] = had_pkg::HW_OEN_RST;
		r[had_pkg::RT1_DESC_IDX] = had_pkg::RT1_DESC_RST;
		r[had_pkg::RT2_DESC_IDX] = had_pkg::RT2_DESC_RST;
		return r;
	endfunction : regReset

	// ---------------------------------------------------------------
	// arbitration and decode
	// ---------------------------------------------------------------
	// alternate priority when both sides wait, so neither starves
	assign grantHost = st_r.hPend && (!st_r.iPend || !st_r.lastHost);
	assign grantInt = st_r.iPend && !grantHost;
	assign gAddr = grantHost ? st_r.hAddr : st_r.iAddr;
	assign isReg = gAddr < had_pkg::RAM_FIRST;
	assign ramEn = (grantHost || grantInt) && !isReg;
	assign ramWe = grantHost ? st_r.hWe : st_r.iWe;
	assign ramBe = (grantHost && st_r.hByte) ? (st_r.hLane ? had_pkg::BE_HI : had_pkg::BE_LO)
		: had_pkg::BE_ALL;
	assign ramWdata = grantHost ? st_r.hData : st_r.iData;
	assign rdWord = st_r.s1Reg ? st_r.s1RegVal : ramRdata;

	had_ram #(
		.AW(had_pkg::WADDR_W),
		.DW(had_pkg::WORD_W),
		.DEPTH(had_pkg::SPACE_WORDS)
	) had_ram_inst (
		.clk(clk),
		.en(ramEn),
		.we(ramWe),
		.be(ramBe),
		.addr(gAddr),
		.wdata(ramWdata),
		.rdata(ramRdata)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.hAck = 1'b0;
		st_nxt.iAck = 1'b0;
		// interface strap caught on the first edge after reset release
		if (!st_r.strapDone) begin
			st_nxt.strapDone = 1'b1;
			st_nxt.busPar = busSelStrap;
		end
		// host request capture, only on the parallel port
		if ((hostRd || hostWr) && !st_r.hBusy && st_r.strapDone && st_r.busPar) begin
			st_nxt.hPend = 1'b1;
			st_nxt.hBusy = 1'b1;
			st_nxt.hWe = hostWr;
			st_nxt.hByte = byteMode;
			st_nxt.hLane = byteMode & hostAddr[0];
			st_nxt.hAddr = hostAddr[15:1];
			st_nxt.hData = byteMode ? {hostWdata[7:0], hostWdata[7:0]} : hostWdata;
		end
		// internal request capture
		if ((intRd || intWr) && !st_r.iBusy) begin
			st_nxt.iPend = 1'b1;
			st_nxt.iBusy = 1'b1;
			st_nxt.iWe = intWr;
			st_nxt.iAddr = intAddr;
			st_nxt.iData = intWdata;
		end
		// granted access: register side done here, RAM side in had_ram
		st_nxt.s1Host = grantHost;
		st_nxt.s1Int = grantInt;
		st_nxt.s1Reg = isReg;
		st_nxt.s1Byte = grantHost && st_r.hByte;
		st_nxt.s1Lane = st_r.hLane;
		st_nxt.s1RegVal = isReg ? st_r.regs[gAddr[6:0]] : 16'h0000;
		if (grantHost) begin
			st_nxt.hPend = 1'b0;
			st_nxt.lastHost = 1'b1;
			if (st_r.hWe && isReg) begin
				st_nxt.regs[gAddr[6:0]] = (st_r.regs[gAddr[6:0]]
					& ~(hostWrMask(gAddr[6:0]) & laneMask(st_r.hByte, st_r.hLane)))
					| (st_r.hData & hostWrMask(gAddr[6:0])
					& laneMask(st_r.hByte, st_r.hLane));
			end
		end
		if (grantInt) begin
			st_nxt.iPend = 1'b0;
			st_nxt.lastHost = 1'b0;
			if (st_r.iWe && isReg) begin
				st_nxt.regs[gAddr[6:0]] = st_r.iData;
			end
		end
		// answers, same latency for register and RAM
		if (st_r.s1Host) begin
			st_nxt.hAck = 1'b1;
			st_nxt.hBusy = 1'b0;
			st_nxt.hRdata = st_r.s1Byte ? {8'h00, (st_r.s1Lane ? rdWord[15:8] : rdWord[7:0])}
				: rdWord;
		end
		if (st_r.s1Int) begin
			st_nxt.iAck = 1'b1;
			st_nxt.iBusy = 1'b0;
			st_nxt.iRdata = rdWord;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.regs <= regReset();
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state flops
	assign hostRdata = st_r.hRdata;
	assign hostAck = st_r.hAck;
	assign hostBusy = st_r.hBusy;
	assign hostIfParallel = st_r.busPar;
	assign intRdata = st_r.iRdata;
	assign intAck = st_r.iAck;
	assign intBusy = st_r.iBusy;
	assign logBase = st_r.regs[had_pkg::LOG_ADDR_IDX];
	assign rt1DescBase = st_r.regs[had_pkg::RT1_DESC_IDX];
	assign rt2DescBase = st_r.regs[had_pkg::RT2_DESC_IDX];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_host_latency: assert property (@(posedge clk) disable iff (!rst_n)
		grantHost |-> ##2 hostAck) else $error("host answer not two edges after grant");
	a_single_grant: assert property (@(posedge clk) disable iff (!rst_n)
		!(grantHost && grantInt)) else $error("both sides granted together");
	a_fair_turn: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r.hPend && st_r.iPend && st_r.lastHost) |-> grantInt) else $error("host starved internal");
	a_ro_protect: assert property (@(posedge clk) disable iff (!rst_n)
		(grantHost && st_r.hWe && isReg && gAddr[6:0] == 7'h01) |=> $stable(st_r.regs[1]))
		else $error("read-only register changed by host");
	a_lane_only: assert property (@(posedge clk) disable iff (!rst_n)
		(ramEn && grantHost && st_r.hByte) |-> $onehot(ramBe)) else $error("byte write hit both lanes");
	a_ram_range: assert property (@(posedge clk) disable iff (!rst_n)
		ramEn |-> (gAddr >= had_pkg::RAM_FIRST)) else $error("RAM enabled below its range");
	a_word_addr: assert property (@(posedge clk) disable iff (!rst_n)
		((hostRd || hostWr) && !hostBusy && st_r.strapDone && st_r.busPar && !byteMode)
		|=> (st_r.hAddr == $past(hostAddr[15:1]) && !st_r.hLane)) else $error("word address wrong");
	a_serial_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r.strapDone && !st_r.busPar) |-> ##2 !hostAck) else $error("parallel answer in serial mode");
	a_int_latency: assert property (@(posedge clk) disable iff (!rst_n)
		grantInt |-> ##2 (intAck && !hostAck)) else $error("internal answer late");
endmodule : host_address_decoder
`default_nettype wire

// ===== tb/had_host_model.sv
// Purpose: host processor model driving the parallel host port
// Assumes: one access outstanding, strobes are one-cycle pulses
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module had_host_model (
	input wire logic clk,
	output logic byteMode,
	output logic [15:0] hostAddr,
	output logic hostRd,
	output logic hostWr,
	output logic [15:0] hostWdata,
	input wire logic [15:0] hostRdata,
	input wire logic hostAck
);
	// idle bus at time zero
	initial begin
		byteMode = 1'b0;
		hostAddr = 16'h0000;
		hostRd = 1'b0;
		hostWr = 1'b0;
		hostWdata = 16'h0000;
	end
	// a byte host doubles a word pointer and adds the lane
	function automatic logic [15:0] byteAddrOf(input logic [14:0] wordPtr, input logic lane);
		return {wordPtr, lane};
	endfunction : byteAddrOf
	// one pulse, then wait a bounded time for the acknowledge
	task automatic access(input logic wr, input logic bm, input logic [15:0] addr,
		input logic [15:0] wdata, output logic [15:0] rdata, output logic acked);
		int n;
		@(posedge clk);
		#1;
		byteMode = bm;
		hostAddr = addr;
		hostWdata = wdata;
		hostRd = !wr;
		hostWr = wr;
		@(posedge clk);
		#1;
		hostRd = 1'b0;
		hostWr = 1'b0;
		hostAddr = ~addr;
		hostWdata = ~wdata;
		acked = 1'b0;
		rdata = 16'h0000;
		for (n = 0; n < 8 && !acked; n++) begin
			@(negedge clk);
			if (hostAck === 1'b1) begin
				acked = 1'b1;
				rdata = hostRdata;
			end
		end
	endtask : access
endmodule : had_host_model
`default_nettype wire

// ===== tb/host_address_decoder_bench.sv
// Purpose: self-checking bench for the host address decoder
// Assumes: host model on the host port, bench drives the internal port
// Notes: strap-off case runs last with its own reset
`timescale 1ns/1ps
`default_nettype none
module host_address_decoder_bench;
	logic clk = 1'b0, rstN = 1'b0, strap = 1'b1, bm, hRd, hWr, hAck, hBusy, hPar;
	logic [15:0] hAddr, hWd, hRdata, lgB, r1B, r2B, iRdata, r;
	logic [14:0] iAddr = 15'h0000;
	logic iRd = 1'b0, iWr = 1'b0, iAck, iBusy, k;
	logic [15:0] iWd = 16'h0000;
	int nErrors = 0, totalChecks = 0;
	host_address_decoder host_address_decoder_inst (.clk(clk), .rst_n(rstN),
		.busSelStrap(strap), .byteMode(bm), .hostAddr(hAddr), .hostRd(hRd), .hostWr(hWr),
		.hostWdata(hWd), .hostRdata(hRdata), .hostAck(hAck), .hostBusy(hBusy),
		.hostIfParallel(hPar), .intAddr(iAddr), .intRd(iRd), .intWr(iWr), .intWdata(iWd),
		.intRdata(iRdata), .intAck(iAck), .intBusy(iBusy), .logBase(lgB),
		.rt1DescBase(r1B), .rt2DescBase(r2B));
	had_host_model had_host_model_inst (.clk(clk), .byteMode(bm), .hostAddr(hAddr),
		.hostRd(hRd), .hostWr(hWr), .hostWdata(hWd), .hostRdata(hRdata), .hostAck(hAck));
	// 50 MHz clock
	always #10 clk = ~clk;
	//----------------------------------------
	// helpers
	//----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic hWrite(input logic b, input logic [15:0] a, input logic [15:0] d);
		logic [15:0] x;
		logic ok;
		had_host_model_inst.access(1'b1, b, a, d, x, ok);
		check({15'h0000, ok}, 16'h0001, "host write ack");
		check({15'h0000, hBusy}, 16'h0000, "host busy after write ack");
	endtask : hWrite
	task automatic hRead(input logic b, input logic [15:0] a, input logic [15:0] e);
		logic [15:0] x;
		logic ok;
		had_host_model_inst.access(1'b0, b, a, 16'h0000, x, ok);
		check({15'h0000, ok}, 16'h0001, "host read ack");
		check(x, e, "host read data");
		check({15'h0000, hBusy}, 16'h0000, "host busy after read ack");
	endtask : hRead
	task automatic intAcc(input logic wr, input logic [14:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		logic seen;
		@(posedge clk);
		#1;
		iAddr = a;
		iWdata_set(d);
		iRd = !wr;
		iWr = wr;
		@(posedge clk);
		#1;
		iRd = 1'b0;
		iWr = 1'b0;
		iAddr = ~a;
		check({15'h0000, iBusy}, 16'h0001, "internal busy while pending");
		q = 16'hDEAD;
		seen = 1'b0;
		for (n = 0; n < 8; n++) begin
			@(negedge clk);
			if (iAck === 1'b1) begin
				q = iRdata;
				seen = 1'b1;
				break;
			end
		end
		check({15'h0000, seen}, 16'h0001, "internal ack");
		check({15'h0000, iBusy}, 16'h0000, "internal busy after ack");
	endtask : intAcc
	task automatic iWdata_set(input logic [15:0] d);
		iWd = d;
	endtask : iWdata_set
	task automatic conclude;
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic testReset;
		check(lgB, had_pkg::LOG_ADDR_RST, "log base reset");
		check(r1B, had_pkg::RT1_DESC_RST, "rt1 base reset");
		check(r2B, had_pkg::RT2_DESC_RST, "rt2 base reset");
		check({15'h0000, hPar}, 16'h0001, "parallel selected");
	endtask : testReset
	task automatic testRam;
		hWrite(1'b0, {had_pkg::RAM_FIRST, 1'b1}, 16'hC3A5);
		hWrite(1'b0, {had_pkg::RAM_LAST, 1'b1}, 16'h5A3C);
		hRead(1'b0, {had_pkg::RAM_FIRST, 1'b0}, 16'hC3A5);
		hRead(1'b0, {had_pkg::RAM_LAST, 1'b0}, 16'h5A3C);
	endtask : testRam
	task automatic testRegs;
		hWrite(1'b0, 16'h0002, 16'hFFFF);
		hRead(1'b0, 16'h0002, 16'h0000);
		hWrite(1'b0, 16'h0014, 16'hFFFF);
		check(lgB, had_pkg::LOG_ADDR_RST & ~had_pkg::MASK_LOG | had_pkg::MASK_LOG, "log");
		hWrite(1'b0, 16'h0032, 16'h1234);
		check(r1B, 16'h1234, "rt1 base");
		hWrite(1'b0, 16'h0044, 16'h8001);
		check(r2B, 16'h8001, "rt2 base");
		hRead(1'b0, 16'h0044, 16'h8001);
	endtask : testRegs
	task automatic testBytes;
		hWrite(1'b0, 16'h0200, 16'hA55A);
		hWrite(1'b1, had_host_model_inst.byteAddrOf(15'h0100, 1'b1), 16'h0033);
		hRead(1'b0, 16'h0200, 16'h335A);
		hRead(1'b1, had_host_model_inst.byteAddrOf(15'h0100, 1'b0), 16'h005A);
		// low lane byte write into a register keeps the high byte
		hWrite(1'b1, had_host_model_inst.byteAddrOf(15'h0019, 1'b0), 16'h0078);
		check(r1B, 16'h1278, "rt1 base low byte");
	endtask : testBytes
	task automatic testCollide;
		fork
			hWrite(1'b0, 16'h0400, 16'h1111);
			intAcc(1'b1, 15'h0201, 16'h2222, r);
		join
		intAcc(1'b0, 15'h0200, 16'h0000, r);
		check(r, 16'h1111, "internal sees host word");
		hRead(1'b0, 16'h0402, 16'h2222);
	endtask : testCollide
	task automatic testStrapOff;
		@(posedge clk);
		#1;
		rstN = 1'b0;
		strap = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rstN = 1'b1;
		repeat (3) @(posedge clk);
		had_host_model_inst.access(1'b0, 1'b0, 16'h0098, 16'h0000, r, k);
		check({15'h0000, k}, 16'h0000, "no ack when serial");
		check({15'h0000, hBusy}, 16'h0000, "no busy when serial");
		check({15'h0000, hPar}, 16'h0000, "serial selected");
	endtask : testStrapOff
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rstN = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		testReset();
		testRam();
		testRegs();
		testBytes();
		testCollide();
		testStrapOff();
		conclude();
	end
	// watchdog
	initial begin
		#1000000;
		nErrors++;
		conclude();
	end
endmodule : host_address_decoder_bench
`default_nettype wire
